/* bench/mdio_station_model.sv */
// Station manager model: makes MDC, sends frames, resolves the MDIO wire
`timescale 1ns/1ns
module mdio_station_model (
	input  wire logic clk_sys,
	input  wire logic mdioOut,
	input  wire logic mdioOeN,
	output logic      mdc,
	output logic      mdioIn
);
	logic mgrOe;
	logic mgrVal;

	// Pull-up wins when neither side drives
	assign mdioIn = !mdioOeN ? mdioOut : (mgrOe ? mgrVal : 1'b1);

	// MDC stands low outside frames
	initial begin
		mdc    = 1'b0;
		mgrOe  = 1'b0;
		mgrVal = 1'b1;
	end

	// One bit time of 16 clocks; data changes only while MDC is low
	task automatic slot(input logic oe, input logic v, output logic seen);
		mgrOe  = oe;
		mgrVal = v;
		repeat (8) @(negedge clk_sys);
		seen = mdioIn;
		mdc  = 1'b1;
		repeat (8) @(negedge clk_sys);
		mdc = 1'b0;
	endtask : slot

	// Preamble of ones, then 32 bits; a read releases TA and data
	task automatic frame(input int pre, input logic [31:0] bits, input logic rd,
		output logic [17:0] got);
		logic s;
		got = '0;
		repeat (pre) slot(1'b1, 1'b1, s);
		for (int i = 31; i >= 0; i--) begin
			slot(!(rd && i < 18), bits[i], s);
			if (i < 18) got[i] = s;
		end
		// Release, then let an edge pass so a following frame never re-drives in one step
		mgrOe = 1'b0;
		@(negedge clk_sys);
	endtask : frame
endmodule : mdio_station_model

/* bench/phy_mdio_mgmt_sva.sv */
// Pin-level checks of the management port
`timescale 1ns/1ns
module phy_mdio_mgmt_sva #(
	parameter int NUM_PORTS = 4
) (
	input wire logic                 clk_sys,
	input wire logic                 nrst,
	input wire logic                 mdc,
	input wire logic                 mdioIn,
	input wire logic                 mdioOut,
	input wire logic                 mdioOeN,
	input wire logic [2:0]           phyAddressStraps,
	input wire logic                 addrReverse,
	input wire logic [NUM_PORTS-1:0] portIrq,
	input wire logic                 mgmtInterruptOut
);
	logic mdcQ;
	int   sinceRise;
	int   drvRises;

	// Clocks since a raw MDC rise; saturates so idle never wraps
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mdcQ      <= 1'b0;
			sinceRise <= 99;
		end else begin
			mdcQ      <= mdc;
			sinceRise <= (mdc && !mdcQ) ? 0 : (sinceRise < 99 ? sinceRise + 1 : 99);
		end
	end

	// MDC rises counted while the pin is driven
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			drvRises <= 0;
		end else begin
			drvRises <= mdioOeN ? 0 : drvRises + ((mdc && !mdcQ) ? 1 : 0);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	chk_turn_zero: assert property ($fell(mdioOeN) |-> !mdioOut)
		else $error("first driven bit is not zero");
	chk_drive_len: assert property ($rose(mdioOeN) |-> drvRises == 17)
		else $error("drive did not span seventeen bit times");
	chk_out_edge: assert property (!$stable(mdioOut) |-> sinceRise inside {[1:6]})
		else $error("data changed away from an MDC rise");
	chk_oe_edge: assert property (!$stable(mdioOeN) |-> sinceRise inside {[1:6]})
		else $error("enable changed away from an MDC rise");
	chk_rel_high: assert property (mdioOeN |-> mdioOut)
		else $error("released pin value not high");
	chk_reset_idle: assert property ($rose(nrst) |-> mdioOeN && !mgmtInterruptOut)
		else $error("outputs not idle after reset");
	chk_irq_cause: assert property ($rose(mgmtInterruptOut) |-> $past(|portIrq))
		else $error("interrupt rose without a request");
	chk_irq_drop: assert property (!(|portIrq) |=> !mgmtInterruptOut)
		else $error("interrupt held without a request");
endmodule : phy_mdio_mgmt_sva

/* bench/phy_mdio_mgmt_tb_top.sv */
// Self-checking bench for the serial management port
`timescale 1ns/1ns
module phy_mdio_mgmt_tb_top;
	logic        clk_sys;
	logic        nrst;
	logic        mdc;
	logic        mdioIn;
	logic        mdioOut;
	logic        mdioOeN;
	logic [2:0]  straps;
	logic        addrRev;
	logic [3:0]  portIrq;
	logic        mgmtInterruptOut;
	logic [17:0] got;
	logic [15:0] mem [int];
	logic [31:0] bad [3] = '{32'h0fffffff, 32'h4fffffff, 32'h7fffffff};
	int          n_mismatch;
	int          n_tests;

	phy_mdio_mgmt phy_mdio_mgmt_i (.clk_sys(clk_sys), .nrst(nrst), .mdc(mdc),
		.mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOeN(mdioOeN), .phyAddressStraps(straps),
		.addrReverse(addrRev), .portIrq(portIrq), .mgmtInterruptOut(mgmtInterruptOut));
	mdio_station_model mdio_station_model_i (.clk_sys(clk_sys), .mdioOut(mdioOut),
		.mdioOeN(mdioOeN), .mdc(mdc), .mdioIn(mdioIn));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [4:0] phyOf(int p);
		return {straps, addrRev ? ~p[1:0] : p[1:0]};
	endfunction : phyOf

	function automatic logic [15:0] mget(int k);
		return mem.exists(k) ? mem[k] : 16'h0000;
	endfunction : mget

	task automatic cmp(string what, logic [15:0] exp, logic [15:0] seen);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : cmp

	// Reference registers; page select, indirect control and address kept per port
	task automatic mdl(int p, int r, bit wr, inout logic [15:0] v);
		int k;
		int fn;
		int dev;
		bit live;
		fn = mget(p * 1000 + 213) / 16'h4000;
		dev = mget(p * 1000 + 213) % 32;
		live = 1'b1;
		k = p * 1000 + 32 * (mget(p * 1000 + 231) % 4) + r;
		if (r == 31 || r == 13) k = p * 1000 + 200 + r;
		if (r == 14) k = p * 1000 + (fn == 0 ? 214 : 300 + mget(p * 1000 + 214) % 16);
		// Data window: two device codes hold storage; the address steps after any access in mode 2 and after writes in mode 3
		if (r == 14 && fn != 0) begin
			live = (dev == 3 || dev == 7);
			if (fn == 2 || (fn == 3 && wr))
				mem[p * 1000 + 214] = mget(p * 1000 + 214) + 16'h0001;
		end
		if (wr && live) mem[k] = v;
		else if (!wr) v = live ? mget(k) : 16'h0000;
	endtask : mdl

	// One frame, judged against the reference; no match means a silent wire
	task automatic acc(logic [4:0] phy, bit wr, int r, logic [15:0] v, int pre);
		int p;
		logic [15:0] e;
		p = -1;
		e = wr ? v : 16'hffff;
		for (int i = 0; i < 4; i++) if (phyOf(i) === phy) p = i;
		if (p >= 0) mdl(p, r, wr, e);
		mdio_station_model_i.frame(pre, {2'h1, wr ? phy_mdio_pkg::OP_WRITE
			: phy_mdio_pkg::OP_READ, phy, r[4:0], 2'h2, v}, !wr, got);
		if (!wr) cmp("turnaround", {14'h0, 1'b1, p < 0}, {14'h0, got[17:16]});
		if (!wr) cmp("read data", e, got[15:0]);
	endtask : acc

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk_sys);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		logic [15:0] v;
		int r;
		n_mismatch = 0;
		n_tests = 0;
		nrst = 1'b0;
		portIrq = 4'h0;
		void'($urandom(49509));
		straps = 3'($urandom);
		addrRev = 1'($urandom);
		repeat (4) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (8) @(negedge clk_sys);
		// Each port, write then read back to back without preamble, except two preamble bits before the port 0 write
		for (int p = 0; p < 4; p++) begin
			r = $urandom_range(30, 15);
			acc(phyOf(p), 1'b1, r, 16'($urandom), p == 0 ? 2 : 0);
			acc(phyOf(p), 1'b0, r, 16'h0000, 0);
		end
		$display("test port access done");
		acc({~straps, 2'h1}, 1'b1, r, 16'h1234, 1);
		acc({~straps, 2'h1}, 1'b0, r, 16'h0000, 0);
		acc(phyOf(3), 1'b0, r, 16'h0000, 0);
		$display("test foreign address done");
		acc(phyOf(2), 1'b1, 31, 16'habc1, 1);
		acc(phyOf(2), 1'b1, 20, 16'($urandom), 0);
		acc(phyOf(2), 1'b0, 31, 16'h0000, 0);
		acc(phyOf(2), 1'b1, 31, 16'h0000, 0);
		acc(phyOf(2), 1'b0, 20, 16'h0000, 0);
		$display("test paging done");
		foreach (bad[i]) begin
			mdio_station_model_i.frame(2, bad[i], 1'b1, got);
			cmp("ignored frame", 16'hffff, got[17:2]);
			acc(phyOf(2), 1'b0, 31, 16'h0000, 1);
		end
		$display("test bad frames done");
		acc(phyOf(1), 1'b1, 13, 16'h0003, 1);
		acc(phyOf(1), 1'b1, 14, 16'h0005, 0);
		acc(phyOf(1), 1'b1, 13, 16'h4003, 0);
		acc(phyOf(1), 1'b1, 14, 16'($urandom), 0);
		acc(phyOf(1), 1'b0, 14, 16'h0000, 0);
		// Stepping modes, the second one on a device code without storage
		acc(phyOf(1), 1'b1, 13, 16'h8007, 0);
		acc(phyOf(1), 1'b1, 14, 16'($urandom), 0);
		acc(phyOf(1), 1'b0, 14, 16'h0000, 0);
		acc(phyOf(1), 1'b1, 13, 16'hc004, 0);
		acc(phyOf(1), 1'b1, 14, 16'h5a5a, 0);
		acc(phyOf(1), 1'b0, 14, 16'h0000, 0);
		acc(phyOf(1), 1'b1, 13, 16'h0004, 0);
		acc(phyOf(1), 1'b0, 14, 16'h0000, 0);
		acc(phyOf(1), 1'b1, 14, 16'h0005, 0);
		acc(phyOf(1), 1'b1, 13, 16'h4007, 0);
		acc(phyOf(1), 1'b0, 14, 16'h0000, 0);
		$display("test indirect access done");
		for (int p = 0; p < 4; p++) acc(phyOf(p), 1'b1, 25, 16'($urandom), 1);
		repeat (12) begin
			portIrq = 4'($urandom);
			repeat (2) @(negedge clk_sys);
			v = 16'h0000;
			for (int p = 0; p < 4; p++) v[0] |= portIrq[p] & (mget(p * 1000 + 25) >= 16'h8000);
			cmp("interrupt", v, {15'h0, mgmtInterruptOut});
		end
		$display("test interrupt done");
		give_verdict();
	end
endmodule : phy_mdio_mgmt_tb_top

bind phy_mdio_mgmt phy_mdio_mgmt_sva #(.NUM_PORTS(NUM_PORTS)) chk_i (.clk_sys(clk_sys),
	.nrst(nrst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOeN(mdioOeN),
	.phyAddressStraps(phyAddressStraps), .addrReverse(addrReverse), .portIrq(portIrq),
	.mgmtInterruptOut(mgmtInterruptOut));

/* rtl/phy_mdio_mgmt.sv */
// Serial management slave: frame decoder, paged registers, indirect access
`timescale 1ns/1ns

// Operation
// - Thirty-two directly addressed sixteen-bit registers per port.
// - Register 31 selects the page seen by the other registers except 13 and 14.
// - Registers 13 and 14 give indirect access to energy-efficiency registers.
// - Incoming data is sampled on MDC rising edges.
// - Read data changes on MDC rising edges.
// - Each transaction is a 32-bit frame, optional preamble before it.
// - Idle leaves MDIO undriven; idle of any length accepted.
// - Frames accepted without preamble straight after a frame, otherwise after any run of ones.
// - Start pattern 01; otherwise ignore bits until next preamble.
// - Opcode 10 reads, 01 writes; others ignored until next preamble.
// - Five-bit address compared with port address; act only on match.
// - Next five bits are the register address.
// - Two turnaround bits; device drives zero on the second in reads.
// - Sixteen read bits, each valid edge to edge.
// - Port address: strap upper bits, port index low bits, optionally reversed.
// - Interrupt out when a port interrupts and its enable bit is set.
module phy_mdio_mgmt #(
	parameter int NUM_PORTS = 4,
	parameter int PAGE_BITS = 2,
	parameter int MMD_AW    = 4
) (
	input  wire logic                 clk_sys,
	input  wire logic                 nrst,
	input  wire logic                 mdc,
	input  wire logic                 mdioIn,
	output logic                      mdioOut,
	output logic                      mdioOeN,
	input  wire logic [2:0]           phyAddressStraps,
	input  wire logic                 addrReverse,
	input  wire logic [NUM_PORTS-1:0] portIrq,
	output logic                      mgmtInterruptOut
);

	localparam int NUM_PAGES = 1 << PAGE_BITS;
	localparam int MMD_DEPTH = 1 << MMD_AW;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [2:0]              mdcSync_ff;
	logic [1:0]              mdioSync_ff;
	logic [2:0]              strapSync0_ff;
	logic [2:0]              strapSync1_ff;
	logic [1:0]              revSync_ff;
	logic [1:0]              settle_ff;
	logic [2:0]              strapLatch_ff;
	logic                    revLatch_ff;
	phy_mdio_pkg::mgmt_state_e state_ff;
	logic [3:0]              bitCnt_ff;
	phy_mdio_pkg::frame_hdr_s hdr_ff;
	phy_mdio_pkg::frame_hdr_s nxtHdr;
	logic                    active_ff;
	logic [1:0]              port_ff;
	logic [15:0]             wrShift_ff;
	logic [15:0]             rdShift_ff;
	logic                    hit;
	logic [1:0]              hitPort;
	logic                    mdcRise;
	logic                    bitIn;
	logic                    isRead;
	logic                    rdFire;
	logic                    wrFire;
	logic [15:0]             wrData;
	logic [15:0]             rdWord;
	logic [15:0]             regs_ff [NUM_PORTS][NUM_PAGES][31];
	logic [15:0]             pageSel_ff [NUM_PORTS];
	logic [15:0]             mmdCtl_ff [NUM_PORTS];
	logic [15:0]             mmdAddr_ff [NUM_PORTS];
	logic [15:0]             mmdMem_ff [NUM_PORTS][MMD_DEPTH];
	logic [NUM_PORTS-1:0]    irqEn;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [4:0] portAddr(input logic [1:0] idx);
		portAddr = {strapLatch_ff, revLatch_ff ? ~idx : idx};
	endfunction : portAddr

	function automatic logic devOk(input logic [1:0] p);
		devOk = (mmdCtl_ff[p][4:0] == phy_mdio_pkg::MMD_DEV_PCS) ||
			(mmdCtl_ff[p][4:0] == phy_mdio_pkg::MMD_DEV_AN);
	endfunction : devOk

	function automatic logic [15:0] readWord(input logic [1:0] p, input logic [4:0] r);
		case (r)
			phy_mdio_pkg::REG_PAGE: readWord = pageSel_ff[p];
			phy_mdio_pkg::REG_MMD_CTL: readWord = mmdCtl_ff[p];
			phy_mdio_pkg::REG_MMD_DATA: begin
				if (mmdCtl_ff[p][15:14] == phy_mdio_pkg::MMD_FN_ADDR)
					readWord = mmdAddr_ff[p];
				else if (devOk(p))
					readWord = mmdMem_ff[p][mmdAddr_ff[p][MMD_AW-1:0]];
				else
					readWord = 16'h0000;
			end
			default: readWord = regs_ff[p][pageSel_ff[p][PAGE_BITS-1:0]][r];
		endcase
	endfunction : readWord

	// ----------------------------------------------------------------
	// Pin synchronisers and MDC edge detect
	// ----------------------------------------------------------------
	// Edge taken from the second and third stages only; the first is metastable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mdcSync_ff  <= 3'h0;
			mdioSync_ff <= 2'h3;
		end else begin
			mdcSync_ff  <= {mdcSync_ff[1:0], mdc};
			mdioSync_ff <= {mdioSync_ff[0], mdioIn};
		end
	end

	assign mdcRise = mdcSync_ff[1] & ~mdcSync_ff[2];
	assign bitIn   = mdioSync_ff[1];

	// Straps are latched on each of the first three clocks after release and held from the third, once the synchronisers have settled
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			strapSync0_ff <= 3'h0;
			strapSync1_ff <= 3'h0;
			revSync_ff    <= 2'h0;
			settle_ff     <= 2'h0;
			strapLatch_ff <= 3'h0;
			revLatch_ff   <= 1'b0;
		end else begin
			strapSync0_ff <= phyAddressStraps;
			strapSync1_ff <= strapSync0_ff;
			revSync_ff    <= {revSync_ff[0], addrReverse};
			if (settle_ff != phy_mdio_pkg::STRAP_SETTLE) begin
				settle_ff     <= settle_ff + 2'h1;
				strapLatch_ff <= strapSync1_ff;
				revLatch_ff   <= revSync_ff[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame decode
	// ----------------------------------------------------------------
	// Address match on the header as it completes
	always_comb begin
		nxtHdr  = phy_mdio_pkg::frame_hdr_s'({hdr_ff[10:0], bitIn});
		hit     = 1'b0;
		hitPort = 2'h0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (nxtHdr.phy == portAddr(2'(p))) begin
				hit     = 1'b1;
				hitPort = 2'(p);
			end
		end
	end

	assign isRead = (hdr_ff.op == phy_mdio_pkg::OP_READ);
	assign rdFire = mdcRise && (state_ff == phy_mdio_pkg::ST_TA) &&
		(bitCnt_ff == phy_mdio_pkg::TA_LAST) && isRead && active_ff;
	assign wrFire = mdcRise && (state_ff == phy_mdio_pkg::ST_DATA) &&
		(bitCnt_ff == phy_mdio_pkg::DATA_LAST) && !isRead && active_ff;
	assign wrData = {wrShift_ff[14:0], bitIn};

	// Word for the read under way, looked up once so the shifter can slice it
	assign rdWord = readWord(port_ff, hdr_ff.regAddr);

	// Starts in skip so a run of ones is needed to arm the decoder
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff   <= phy_mdio_pkg::ST_SKIP;
			bitCnt_ff  <= 4'h0;
			hdr_ff     <= '0;
			active_ff  <= 1'b0;
			port_ff    <= 2'h0;
			wrShift_ff <= 16'h0000;
		end else if (mdcRise) begin
			bitCnt_ff <= bitCnt_ff + 4'h1;
			case (state_ff)
				phy_mdio_pkg::ST_SKIP, phy_mdio_pkg::ST_IDLE: begin
					if (bitIn)
						state_ff <= phy_mdio_pkg::ST_PRE;
				end
				phy_mdio_pkg::ST_PRE: begin
					if (!bitIn)
						state_ff <= phy_mdio_pkg::ST_SFD;
				end
				phy_mdio_pkg::ST_SFD: begin
					bitCnt_ff <= 4'h0;
					state_ff  <= bitIn ? phy_mdio_pkg::ST_HDR : phy_mdio_pkg::ST_SKIP;
				end
				phy_mdio_pkg::ST_HDR: begin
					hdr_ff <= nxtHdr;
					if (bitCnt_ff == phy_mdio_pkg::OP_LAST &&
						nxtHdr[1:0] != phy_mdio_pkg::OP_READ &&
						nxtHdr[1:0] != phy_mdio_pkg::OP_WRITE)
						state_ff <= phy_mdio_pkg::ST_SKIP;
					else if (bitCnt_ff == phy_mdio_pkg::HDR_LAST) begin
						active_ff <= hit;
						port_ff   <= hitPort;
						bitCnt_ff <= 4'h0;
						state_ff  <= phy_mdio_pkg::ST_TA;
					end
				end
				phy_mdio_pkg::ST_TA: begin
					if (bitCnt_ff == phy_mdio_pkg::TA_LAST) begin
						bitCnt_ff <= 4'h0;
						state_ff  <= phy_mdio_pkg::ST_DATA;
					end
				end
				phy_mdio_pkg::ST_DATA: begin
					wrShift_ff <= wrData;
					// Frame done; idle ones act as the next preamble
					if (bitCnt_ff == phy_mdio_pkg::DATA_LAST)
						state_ff <= phy_mdio_pkg::ST_PRE;
				end
				default: state_ff <= phy_mdio_pkg::ST_SKIP;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// MDIO drive
	// ----------------------------------------------------------------
	// Changes only on a detected rising edge, holds until the next one
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mdioOut    <= 1'b1;
			mdioOeN    <= 1'b1;
			rdShift_ff <= 16'h0000;
		end else if (mdcRise) begin
			if (state_ff == phy_mdio_pkg::ST_TA && isRead && active_ff) begin
				if (bitCnt_ff == 4'h0) begin
					mdioOut <= 1'b0;
					mdioOeN <= 1'b0;
				end else begin
					mdioOut    <= rdWord[15];
					rdShift_ff <= {rdWord[14:0], 1'b0};
				end
			end else if (state_ff == phy_mdio_pkg::ST_DATA && isRead && active_ff &&
				bitCnt_ff != phy_mdio_pkg::DATA_LAST) begin
				mdioOut    <= rdShift_ff[15];
				rdShift_ff <= {rdShift_ff[14:0], 1'b0};
			end else begin
				mdioOut <= 1'b1;
				mdioOeN <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Flop storage; pages bank registers 0..30 except 13 and 14; registers 13, 14 and 31 are shared per port
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				pageSel_ff[p] <= phy_mdio_pkg::REG_RESET;
				mmdCtl_ff[p]  <= phy_mdio_pkg::REG_RESET;
				mmdAddr_ff[p] <= phy_mdio_pkg::REG_RESET;
				for (int m = 0; m < MMD_DEPTH; m++)
					mmdMem_ff[p][m] <= phy_mdio_pkg::REG_RESET;
				for (int g = 0; g < NUM_PAGES; g++)
					for (int r = 0; r < 31; r++)
						regs_ff[p][g][r] <= phy_mdio_pkg::REG_RESET;
			end
		end else if (wrFire) begin
			case (hdr_ff.regAddr)
				phy_mdio_pkg::REG_PAGE: pageSel_ff[port_ff] <= wrData;
				phy_mdio_pkg::REG_MMD_CTL: mmdCtl_ff[port_ff] <= wrData;
				phy_mdio_pkg::REG_MMD_DATA: begin
					if (mmdCtl_ff[port_ff][15:14] == phy_mdio_pkg::MMD_FN_ADDR)
						mmdAddr_ff[port_ff] <= wrData;
					else begin
						if (devOk(port_ff))
							mmdMem_ff[port_ff][mmdAddr_ff[port_ff][MMD_AW-1:0]] <= wrData;
						if (mmdCtl_ff[port_ff][15:14] != 2'h1)
							mmdAddr_ff[port_ff] <= mmdAddr_ff[port_ff] + 16'h0001;
					end
				end
				default: regs_ff[port_ff][pageSel_ff[port_ff][PAGE_BITS-1:0]]
					[hdr_ff.regAddr] <= wrData;
			endcase
		end else if (rdFire && hdr_ff.regAddr == phy_mdio_pkg::REG_MMD_DATA &&
			mmdCtl_ff[port_ff][15:14] == phy_mdio_pkg::MMD_FN_INC_RW) begin
			// Read post-increment only in the read-and-write increment mode
			mmdAddr_ff[port_ff] <= mmdAddr_ff[port_ff] + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++)
			irqEn[p] = regs_ff[p][0][phy_mdio_pkg::REG_IRQ_CFG][phy_mdio_pkg::IRQ_EN_BIT];
	end

	// Registered so the pin never glitches on enable changes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst)
			mgmtInterruptOut <= 1'b0;
		else
			mgmtInterruptOut <= |(portIrq & irqEn);
	end

endmodule : phy_mdio_mgmt

/* rtl/phy_mdio_pkg.sv */
// Shared constants and types for the PHY serial management port
package phy_mdio_pkg;

	// ----------------------------------------------------------------
	// Frame codes
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;

	// ----------------------------------------------------------------
	// Direct register numbers and fields
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_MMD_CTL  = 5'h0d;
	localparam logic [4:0] REG_MMD_DATA = 5'h0e;
	localparam logic [4:0] REG_IRQ_CFG  = 5'h19;
	localparam logic [4:0] REG_PAGE     = 5'h1f;
	localparam int         IRQ_EN_BIT   = 15;
	localparam logic [15:0] REG_RESET   = 16'h0000;

	// ----------------------------------------------------------------
	// Indirect extended-register access
	// ----------------------------------------------------------------
	localparam logic [1:0] MMD_FN_ADDR   = 2'h0;
	localparam logic [1:0] MMD_FN_INC_RW = 2'h2;
	localparam logic [1:0] MMD_FN_INC_W  = 2'h3;
	localparam logic [4:0] MMD_DEV_PCS   = 5'h03;
	localparam logic [4:0] MMD_DEV_AN    = 5'h07;

	// ----------------------------------------------------------------
	// Bit counts within a frame (last index of each field), and the strap settle count
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_LAST   = 4'h1;
	localparam logic [3:0] HDR_LAST  = 4'hb;
	localparam logic [3:0] TA_LAST   = 4'h1;
	localparam logic [3:0] DATA_LAST = 4'hf;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PRE  = 3'h1,
		ST_SFD  = 3'h3,
		ST_HDR  = 3'h2,
		ST_TA   = 3'h6,
		ST_DATA = 3'h7,
		ST_SKIP = 3'h5
	} mgmt_state_e;

	typedef struct packed {
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] regAddr;
	} frame_hdr_s;

endpackage : phy_mdio_pkg
